// ---- lvds_front_cfg.svh ----
// Purpose: constants for the dual converter input front end
// Assumes: included by bare name
// Notes: definitions only
`ifndef LVDS_FRONT_CFG_SVH
`define LVDS_FRONT_CFG_SVH
`define BUS_WIDTH        8
`define SAMPLE_WIDTH     16
`define FIFO_DEPTH       16
`define FIFO_ADDR_BITS   4
`define BYTES_PER_FRAME  3'd4
`define LAST_BYTE        2'd3
`define ZERO_SAMPLE      16'h0000
`define FULL_CODE        16'hffff
`define DIVIDER_BITS     2
`define DIVIDER_RESET    2'h0
`endif

// ---- lvds_front_pkg.sv ----
// Purpose: types for the dual converter input front end
// Assumes: nothing
// Notes: frame layout is a-hi, a-lo, b-hi, b-lo
package lvds_front_pkg;
    typedef struct packed
    {
        logic [15:0] chan_a;
        logic [15:0] chan_b;
    } sample_pair_t;

    typedef struct packed
    {
        logic [15:0] primary;
        logic [15:0] complement;
    } current_code_t;

    typedef enum logic [1:0]
    {
        byte_a_high = 2'b00,
        byte_a_low  = 2'b01,
        byte_b_high = 2'b10,
        byte_b_low  = 2'b11
    } byte_slot_t;
endpackage : lvds_front_pkg

// ---- sample_fifo.sv ----
// Purpose: small sample fifo with valid/ready on both sides
// Assumes: one clock, synchronous flush
// Notes: read data comes from a register
`timescale 1ns/1ps
module sample_fifo
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int ABITS = 4
)
(
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [ABITS:0]   wr_ptr;
    logic [ABITS:0]   rd_ptr;
    wire              empty = (wr_ptr == rd_ptr);
    wire              full  = (wr_ptr[ABITS-1:0] == rd_ptr[ABITS-1:0]) && (wr_ptr[ABITS] != rd_ptr[ABITS]);
    wire              pop   = !empty && (!out_valid || out_ready);
    wire              push  = in_valid && !full;

    assign in_ready = !full;

    always_ff @(posedge clock)
    begin
        if (push)
            mem[wr_ptr[ABITS-1:0]] <= in_data;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end
        else if (flush)
        begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            out_valid <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
            begin
                rd_ptr    <= rd_ptr + 1'b1;
                out_data  <= mem[rd_ptr[ABITS-1:0]];
                out_valid <= 1'b1;
            end
            else if (out_ready)
                out_valid <= 1'b0;
        end
    end
endmodule : sample_fifo

// ---- lvds_input_front.sv ----
// Purpose: capture of the ddr byte bus, framing, fifo, gating and pin roles
// Assumes: ddr data arrive as two bytes per clock (rise, fall) already synchronous
// Notes on behaviour
// [R1] take data on both data clock edges
// [R2] frame marker sampled rising starts new frame
// [R3] frame marker also resets the fifo (code flushes only on a marker while started is low)
// [R4] host edge-aligns frame marker with data
// [R5] offset binary: zero code gives full sink
// [R6] complement output behaves inversely to primary
// [R7] sync strobe on rising edge resets dividers
// [R8] gate low forces datapath zeros
// [R9] serial select is active-low input only
// [R10] serial data pin is bidirectional
// [R11] reference select set makes pin input
// [R12] two 16-bit channels sent bytewise, bit7 msb
// [R13] configuration bit reverses bus bit order
// [R14] four-wire mode makes alarm pin serial output
// [R15] frame byte layout fixed with host
// [R16] fifo carries data to converter side
`timescale 1ns/1ps
`include "lvds_front_cfg.svh"
module lvds_input_front
    import lvds_front_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic [7:0] data_rise,
    input  wire logic [7:0] data_fall,
    input  wire logic       frame_marker,
    input  wire logic       output_sync_strobe,
    input  wire logic       transmit_gate,
    input  wire logic       reverse_bus,
    input  wire logic       serial_select_n,
    input  wire logic       serial_data_in,
    input  wire logic       serial_read_drive,
    input  wire logic       serial_read_bit,
    input  wire logic       four_wire_serial_select,
    input  wire logic       alarm_event,
    input  wire logic       alarm_polarity_high,
    input  wire logic       external_reference_select,
    input  wire logic       sample_ready,
    output logic            serial_data_out,
    output logic            serial_data_oe,
    output logic            serial_write_bit,
    output logic            serial_write_valid,
    output logic            alarm_or_serial_out,
    output logic            reference_io_oe,
    output logic            internal_reference_on,
    output logic            divider_phase_tick,
    output logic            fifo_overflow,
    output logic            sample_valid,
    output current_code_t   chan_a_current,
    output current_code_t   chan_b_current
);
    // shared by the rising and falling bytes of the ddr pair
    function automatic logic [7:0] order_bits(input logic [7:0] b, input logic rev);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < `BUS_WIDTH; i++)
            r[i] = rev ? b[`BUS_WIDTH-1-i] : b[i];
        return r;
    endfunction : order_bits

    wire  [7:0]   byte_rise = order_bits(data_rise, reverse_bus); // [R13] [R12]
    wire  [7:0]   byte_fall = order_bits(data_fall, reverse_bus); // [R13] [R12]

    logic [1:0]   pair_index;
    logic [7:0]   a_high;
    logic [7:0]   b_high;
    logic         word_valid;
    sample_pair_t word;
    logic         fifo_ready;
    logic         out_valid;
    sample_pair_t out_word;
    logic         started;

    // marker taken with the rising byte; pair 0 = a hi/lo, pair 1 = b hi/lo
    wire          frame_start = frame_marker; // [R2] [R4] [R15]
    wire          gate_open   = transmit_gate; // [R8]
    wire          accept_pair = gate_open && (frame_start || started);
    wire          last_pair   = frame_start ? 1'b0 : (pair_index == 2'd1);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pair_index <= '0;
            a_high     <= '0;
            b_high     <= '0;
            started    <= 1'b0;
            word_valid <= 1'b0;
            word       <= '0;
        end
        else
        begin
            word_valid <= 1'b0;
            if (!gate_open)
                started <= 1'b0; // [R8]
            else if (accept_pair)
            begin
                started <= 1'b1;
                if (frame_start || !last_pair) // [R1] [R2]
                begin
                    a_high     <= byte_rise;
                    b_high     <= byte_fall;
                    pair_index <= 2'd1;
                end
                else
                begin
                    word       <= '{chan_a: {a_high, b_high}, chan_b: {byte_rise, byte_fall}}; // [R12]
                    word_valid <= 1'b1;
                    pair_index <= 2'd0;
                end
            end
        end
    end

    sample_fifo #(
        .WIDTH (2*`SAMPLE_WIDTH),
        .DEPTH (`FIFO_DEPTH),
        .ABITS (`FIFO_ADDR_BITS)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .flush     (frame_start && !started), // [R3] [R16]
        .in_valid  (word_valid),
        .in_ready  (fifo_ready),
        .in_data   (word),
        .out_valid (out_valid),
        .out_ready (sample_ready),
        .out_data  (out_word)
    );

    wire  [15:0] code_a = gate_open ? out_word.chan_a : `ZERO_SAMPLE; // [R8]
    wire  [15:0] code_b = gate_open ? out_word.chan_b : `ZERO_SAMPLE; // [R8]
    logic [`DIVIDER_BITS-1:0] divider;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            chan_a_current     <= '{primary: `FULL_CODE, complement: `ZERO_SAMPLE};
            chan_b_current     <= '{primary: `FULL_CODE, complement: `ZERO_SAMPLE};
            sample_valid       <= 1'b0;
            fifo_overflow      <= 1'b0;
            divider            <= `DIVIDER_RESET;
            divider_phase_tick <= 1'b0;
        end
        else
        begin
            // sink level: zero code = full sink on primary
            chan_a_current     <= '{primary: `FULL_CODE - code_a, complement: code_a}; // [R5] [R6]
            chan_b_current     <= '{primary: `FULL_CODE - code_b, complement: code_b}; // [R5] [R6]
            sample_valid       <= out_valid && gate_open;
            fifo_overflow      <= word_valid && !fifo_ready;
            divider            <= output_sync_strobe ? `DIVIDER_RESET : divider + 1'b1; // [R7]
            divider_phase_tick <= output_sync_strobe || (divider == `DIVIDER_RESET); // [R7]
        end
    end

    wire alarm_level = alarm_polarity_high ? alarm_event : !alarm_event;
    wire selected    = !serial_select_n; // [R9]

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            serial_data_out       <= 1'b0;
            serial_data_oe        <= 1'b0;
            serial_write_bit      <= 1'b0;
            serial_write_valid    <= 1'b0;
            alarm_or_serial_out   <= 1'b1;
            reference_io_oe       <= 1'b1;
            internal_reference_on <= 1'b1;
        end
        else
        begin
            // reads drive the data pin in both modes; four-wire mode also copies them to the alarm pin
            serial_data_out       <= serial_read_bit;
            serial_data_oe        <= selected && serial_read_drive; // [R10]
            serial_write_bit      <= serial_data_in;
            serial_write_valid    <= selected && !serial_read_drive; // [R9] [R10]
            alarm_or_serial_out   <= four_wire_serial_select ? serial_read_bit : alarm_level; // [R14]
            reference_io_oe       <= !external_reference_select; // [R11]
            internal_reference_on <= !external_reference_select; // [R11]
        end
    end
endmodule : lvds_input_front

// ---- host_source.sv ----
// Purpose: host side source of the ddr byte bus
// Assumes: a frame is two clocks, channel a then b
// Notes: idle bus toggles; once framed the front end streams these bytes as samples too
`timescale 1ns/1ps
module host_source
(
    input  wire logic        clock,
    input  wire logic        go,
    input  wire logic [31:0] pair,
    output logic      [7:0]  data_rise,
    output logic      [7:0]  data_fall,
    output logic             frame_marker
);
    logic second = 1'b0;
    initial {data_rise, data_fall, frame_marker} = 17'h0;
    always @(negedge clock)
    begin
        frame_marker <= go && !second;
        if (second)
            {data_rise, data_fall} <= pair[15:0];
        else if (go)
            {data_rise, data_fall} <= pair[31:16];
        else
            {data_rise, data_fall} <= ~{data_rise, data_fall};
        second <= go && !second;
    end
endmodule : host_source

// ---- front_props.sv ----
// Purpose: port properties of the input front end
// Assumes: one clock, async high reset
// Notes: bound from tb_top
`timescale 1ns/1ps
module front_props
    import lvds_front_pkg::*;
(
    input wire logic          clock,
    input wire logic          rst,
    input wire logic          transmit_gate,
    input wire logic          output_sync_strobe,
    input wire logic          serial_select_n,
    input wire logic          serial_read_drive,
    input wire logic          serial_read_bit,
    input wire logic          four_wire_serial_select,
    input wire logic          external_reference_select,
    input wire logic          serial_data_oe,
    input wire logic          alarm_or_serial_out,
    input wire logic          reference_io_oe,
    input wire logic          internal_reference_on,
    input wire logic          divider_phase_tick,
    input wire logic          sample_valid,
    input wire current_code_t chan_a_current,
    input wire current_code_t chan_b_current
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    AST_EXT_REF: assert property (external_reference_select |=> !reference_io_oe && !internal_reference_on)
        else $error("reference pin still driven");
    AST_SDO_DRIVE: assert property (serial_data_oe |-> !$past(serial_select_n) && $past(serial_read_drive))
        else $error("data pin driven out of turn");
    AST_SDO_BOTH: assert property (!serial_select_n && serial_read_drive |=> serial_data_oe)
        else $error("data pin not driven for a read");
    AST_ALARM_OR_SERIAL_OUT: assert property (four_wire_serial_select |=> alarm_or_serial_out == $past(serial_read_bit))
        else $error("alarm pin not carrying read data");
    AST_INV_A: assert property (chan_a_current.primary == ~chan_a_current.complement)
        else $error("channel a outputs not complementary");
    AST_INV_B: assert property (chan_b_current.primary == ~chan_b_current.complement)
        else $error("channel b outputs not complementary");
    AST_GATE_VALID: assert property (!transmit_gate |=> !sample_valid)
        else $error("sample passed with gate low");
    AST_GATE_ZERO: assert property (!transmit_gate [*3] |=> chan_a_current.complement == 16'h0000
        && chan_b_current.complement == 16'h0000) else $error("datapath not zero with gate low");
    AST_SYNC_TICK: assert property (output_sync_strobe |=> divider_phase_tick)
        else $error("strobe did not reset divider");
    cover property (sample_valid ##1 sample_valid);
    cover property (!transmit_gate ##1 transmit_gate);
    cover property (serial_data_oe);
endmodule : front_props

// ---- tb_top.sv ----
// Purpose: self-checking bench for the input front end
// Assumes: host_source drives the byte bus
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module tb_top
    import lvds_front_pkg::*;
;
    logic          clock = 1'b0, rst = 1'b1, go = 1'b0, frame_marker, ovf_seen = 1'b0;
    logic [31:0]   pair = 32'h0;
    logic [7:0]    data_rise, data_fall;
    logic          output_sync_strobe = 1'b0, transmit_gate = 1'b1, reverse_bus = 1'b0, sample_ready = 1'b1;
    logic          serial_select_n = 1'b1, serial_data_in = 1'b0, serial_read_drive = 1'b0, serial_read_bit = 1'b0;
    logic          four_wire_serial_select = 1'b0, alarm_event = 1'b0, alarm_polarity_high = 1'b0;
    logic          external_reference_select = 1'b0, serial_data_out, serial_data_oe, serial_write_bit;
    logic          serial_write_valid, alarm_or_serial_out, reference_io_oe, internal_reference_on;
    logic          divider_phase_tick, fifo_overflow, sample_valid;
    current_code_t chan_a_current, chan_b_current;
    int            miscompares = 0, check_count = 0;
    lvds_input_front dut (.*);
    host_source host (.*);
    always #2.5 clock = ~clock;
    always @(posedge clock) if (fifo_overflow) ovf_seen <= 1'b1;
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    // called on a falling edge; holds go up unless last is set, so frames run back to back
    task automatic send(input logic [31:0] p, input bit last);
        pair <= p;
        go <= 1'b1;
        repeat (2) @(negedge clock);
        if (last) go <= 1'b0;
    endtask : send
    task automatic wait_valid();
        int i;
        for (i = 0; i < 40 && sample_valid !== 1'b1; i++) @(negedge clock);
        if (i == 40)
        begin
            miscompares++;
            end_of_test();
        end
    endtask : wait_valid
    task automatic t_frame();
        for (int r = 0; r < 2; r++)
        begin
            reverse_bus <= r[0];
            send(32'h12c4_0f35, 1);
            // idle bytes stream as samples too, so look at the fixed latency instead of the first valid
            repeat (4) @(negedge clock);
            check(sample_valid, 1);
            check(chan_a_current.complement, r ? 16'h4823 : 16'h12c4);
            check(chan_b_current, r ? 32'h0f53_f0ac : 32'hf0ca_0f35);
        end
        reverse_bus <= 1'b0;
        $display("frame test done");
    endtask : t_frame
    task automatic t_gate();
        transmit_gate <= 1'b0;
        send(32'h5a5a_a5a5, 1);
        repeat (8) @(negedge clock);
        check(sample_valid, 0);
        check({chan_a_current, chan_b_current}, {2{32'hffff_0000}});
        transmit_gate <= 1'b1;
        $display("gate test done");
    endtask : t_gate
    task automatic t_pins();
        logic [3:0] ticks;
        serial_select_n <= 1'b0;
        serial_data_in <= 1'b1;
        @(negedge clock);
        check({serial_write_valid, serial_write_bit, serial_data_oe}, 3'b110);
        serial_read_drive <= 1'b1;
        serial_read_bit <= 1'b1;
        @(negedge clock);
        check({serial_data_oe, serial_data_out, serial_write_valid}, 3'b110);
        four_wire_serial_select <= 1'b1;
        serial_read_bit <= 1'b0;
        @(negedge clock);
        check({serial_data_oe, alarm_or_serial_out}, 2'b10);
        serial_select_n <= 1'b1;
        external_reference_select <= 1'b1;
        output_sync_strobe <= 1'b1;
        @(negedge clock);
        output_sync_strobe <= 1'b0;
        check({reference_io_oe, internal_reference_on, divider_phase_tick}, 3'b001);
        four_wire_serial_select <= 1'b0;
        alarm_event <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clock);
            ticks = {ticks[2:0], divider_phase_tick};
        end
        check(ticks, 4'b1000);
        check(alarm_or_serial_out, 0);
        alarm_polarity_high <= 1'b1;
        @(negedge clock);
        check(alarm_or_serial_out, 1);
        $display("pin test done");
    endtask : t_pins
    task automatic t_fill();
        logic [31:0] w;
        sample_ready <= 1'b0;
        for (int k = 0; k < 20; k++) send(32'h0f1e_2d3c ^ {4{k[7:0]}}, k == 19);
        check(ovf_seen, 1);
        sample_ready <= 1'b1;
        wait_valid();
        // outputs lag the fifo by a clock: word 0 stands twice, then the 16 queued words in order
        for (int k = 0; k < 18; k++)
        begin
            w = 32'h0f1e_2d3c ^ {4{8'((k == 0) ? 0 : k - 1)}};
            check({sample_valid, chan_a_current.complement, chan_b_current.complement}, {1'b1, w});
            @(negedge clock);
        end
        // word 17 was dropped on the full fifo
        check(chan_a_current.complement != 16'h1e0f, 1);
        $display("fifo test done");
    endtask : t_fill
    initial
    begin
        repeat (8) @(posedge clock);
        @(negedge clock);
        check({alarm_or_serial_out, reference_io_oe, chan_a_current.primary}, 18'h3ffff);
        rst <= 1'b0;
        @(negedge clock);
        t_frame();
        t_gate();
        t_pins();
        t_fill();
        end_of_test();
    end
endmodule : tb_top
bind lvds_input_front front_props u_props (.*);
